// >>> hw/spp_device.sv
`timescale 1ns/1ps
// How it works
// - Read data leaves serial output each falling edge
// - Enabled interrupt pulls serial output low
// - Host holds select low to see interrupt
// - Input bits captured on serial clock
// - Traffic honoured only while select low
// - Select edges frame a clock that stops between frames
// - Select rising resets port to idle
// - Field one takes conversion clock from pin0
// - Rate and notches scale with external clock
// - Pins 0/1 register-controlled unless clock
module spp_device (
    spp_if.dev LINK,
    input wire logic SYS_RST,
    input wire logic INT_CLK,
    input wire logic IRQ_EVENT,
    input wire logic GIO0_I,
    output logic GIO0_O,
    output logic GIO0_OE,
    input wire logic GIO1_I,
    output logic GIO1_O,
    output logic GIO1_OE,
    output logic CONV_CLK,
    output logic EXT_CLK_SEL
);
    // ------------------------------------------------------------
    // Registers, mostly in the serial clock domain
    // ------------------------------------------------------------
    logic [7:0] gpio_cfg_reg; // [1:0] drive enable, [3:2] levels
    logic [7:0] clk_cfg_reg; // Bit 0 is the clock select field
    logic [7:0] irq_en_reg; // Bit 0 enables interrupt indication
    logic [7:0] scratch_reg; // Plain storage
    logic [4:0] bit_cnt_reg; // Bits taken in this frame
    logic [7:0] cmd_reg; // Command byte
    logic [7:0] shin_reg; // Incoming data bits
    logic [7:0] shout_reg; // Outgoing data bits
    logic rd_reg; // Frame is a read
    logic [1:0] irq_sync_reg; // Event into serial domain, for status
    logic [1:0] irq_pin_sync_reg; // Event into internal clock domain
    logic [1:0] rst_sync_reg; // Reset into serial domain
    logic [1:0] gio_sync_reg; // Pin 1 into serial domain
    logic [1:0] gio0_sync_reg; // Pin 0 into serial domain
    logic rst_s; // Synchronised reset
    logic ext_clk_sel; // Clock select field
    logic [7:0] rd_word; // Word chosen by address
    logic sel_n; // Current select level
    logic data_phase; // Read data owns the output line
    logic irq_show; // Interrupt may pull the line low
    // Select is also an asynchronous clear, so it is used raw
    assign sel_n = LINK.device_select_n;
    assign rst_s = rst_sync_reg[1];
    assign ext_clk_sel = (clk_cfg_reg[0] == spp_pkg::EXT_CLOCK_ON);
    // ------------------------------------------------------------
    // Crossings into the serial clock domain
    // ------------------------------------------------------------
    // Serial clock may stop; these only update while it runs, so a
    // reset needs a frame of clock before it takes hold
    always_ff @(posedge LINK.sclk)
    begin
        rst_sync_reg <= {rst_sync_reg[0], SYS_RST};
    end
    // Event level for the status word, read inside a frame
    always_ff @(posedge LINK.sclk)
    begin
        irq_sync_reg <= {irq_sync_reg[0], IRQ_EVENT};
    end
    // Pin levels for the status word; two stages each
    always_ff @(posedge LINK.sclk)
    begin
        gio_sync_reg <= {gio_sync_reg[0], GIO1_I};
        gio0_sync_reg <= {gio0_sync_reg[0], GIO0_I};
    end
    // ------------------------------------------------------------
    // Crossing into the internal clock domain
    // ------------------------------------------------------------
    // The line must follow the event between frames, when the serial
    // clock is stopped, so this copy runs on the free internal clock
    always_ff @(posedge INT_CLK)
    begin
        irq_pin_sync_reg <= {irq_pin_sync_reg[0], IRQ_EVENT};
    end
    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    // Select high holds the counter clear asynchronously, so the
    // rising select both resets and frames the next transfer
    always_ff @(posedge LINK.sclk or posedge sel_n)
    begin
        if (sel_n)
        begin
            bit_cnt_reg <= 5'h00;
            cmd_reg <= 8'h00;
            shin_reg <= 8'h00;
            rd_reg <= 1'b0;
        end
        else if (bit_cnt_reg < 5'(spp_pkg::FRAME_BITS))
        begin
            // Sample on rising edge, MSB first
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg < 5'(spp_pkg::CMD_BITS))
                cmd_reg <= {cmd_reg[6:0], LINK.serial_in};
            else
                shin_reg <= {shin_reg[6:0], LINK.serial_in};
            if (bit_cnt_reg == 5'(spp_pkg::CMD_BITS - 1))
                rd_reg <= cmd_reg[6];
        end
    end
    // ------------------------------------------------------------
    // Register writes at end of frame
    // ------------------------------------------------------------
    always_ff @(posedge LINK.sclk)
    begin
        if (rst_s)
        begin
            gpio_cfg_reg <= spp_pkg::GPIO_CFG_RST;
            clk_cfg_reg <= spp_pkg::CLK_CFG_RST;
            irq_en_reg <= spp_pkg::IRQ_EN_RST;
            scratch_reg <= spp_pkg::SCRATCH_RST;
        end
        else if (!sel_n && !rd_reg &&
                 bit_cnt_reg == 5'(spp_pkg::FRAME_BITS - 1))
        begin
            // Last data bit joins the word here
            unique case (cmd_reg[6:0])
                spp_pkg::ADDR_GPIO_CFG:
                    gpio_cfg_reg <= {shin_reg[6:0], LINK.serial_in};
                spp_pkg::ADDR_CLK_CFG:
                    clk_cfg_reg <= {shin_reg[6:0], LINK.serial_in};
                spp_pkg::ADDR_IRQ_EN:
                    irq_en_reg <= {shin_reg[6:0], LINK.serial_in};
                spp_pkg::ADDR_SCRATCH:
                    scratch_reg <= {shin_reg[6:0], LINK.serial_in};
                default:
                    scratch_reg <= scratch_reg; // Unmapped: ignored
            endcase
        end
    end
    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (cmd_reg[6:0])
            spp_pkg::ADDR_GPIO_CFG: rd_word = gpio_cfg_reg;
            spp_pkg::ADDR_CLK_CFG: rd_word = clk_cfg_reg;
            spp_pkg::ADDR_IRQ_EN: rd_word = irq_en_reg;
            spp_pkg::ADDR_STATUS:
                rd_word = {5'h00, gio_sync_reg[1], gio0_sync_reg[1],
                    irq_sync_reg[1]};
            spp_pkg::ADDR_SCRATCH: rd_word = scratch_reg;
            default: rd_word = 8'h00;
        endcase
    end
    // ------------------------------------------------------------
    // Transmit path, launched on falling edge
    // ------------------------------------------------------------
    // Word is taken at the falling edge that ends the command byte
    always_ff @(negedge LINK.sclk or posedge sel_n)
    begin
        if (sel_n)
            shout_reg <= 8'h00;
        else if (rd_reg && bit_cnt_reg == 5'(spp_pkg::CMD_BITS))
            shout_reg <= rd_word;
        else if (rd_reg)
            shout_reg <= {shout_reg[6:0], 1'b0};
    end
    // ------------------------------------------------------------
    // Shared output line
    // ------------------------------------------------------------
    // Data phase starts at the eighth rising edge, a half bit before the
    // falling edge that loads the word; the first data bit stands before the ninth rising edge
    assign data_phase = rd_reg && !sel_n &&
        bit_cnt_reg >= 5'(spp_pkg::CMD_BITS);
    // Enabled event, shown only while the host holds select low
    assign irq_show = !sel_n && irq_en_reg[0] && irq_pin_sync_reg[1];
    // Data phase of a read shows data; otherwise the interrupt level.
    // Limitation: an event arriving mid-command shows on the line too
    always_comb
    begin
        if (data_phase)
        begin
            // Read bit, MSB first
            LINK.serial_out_irq_n = shout_reg[7];
        end
        else if (irq_show)
        begin
            // Active-low interrupt indication
            LINK.serial_out_irq_n = 1'b0;
        end
        else
        begin
            // Idle line rests high
            LINK.serial_out_irq_n = 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Clock select and general pins
    // ------------------------------------------------------------
    // Glitch-free switching is left to the clock cell; the core
    // simply follows pin 0, so its rates scale with that clock
    assign CONV_CLK = ext_clk_sel ? GIO0_I : INT_CLK;
    assign EXT_CLK_SEL = ext_clk_sel;
    // Pin 0 never drives against an incoming conversion clock
    assign GIO0_OE = gpio_cfg_reg[0] & ~ext_clk_sel;
    assign GIO0_O = gpio_cfg_reg[2];
    assign GIO1_OE = gpio_cfg_reg[1];
    assign GIO1_O = gpio_cfg_reg[3];
endmodule // spp_device

// >>> hw/spp_pkg.sv
package spp_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16; // Bits in one serial frame
    localparam int CMD_BITS = 8; // Leading command byte
    localparam int DATA_BITS = 8; // Trailing data byte
    localparam logic [7:0] CMD_READ_BIT = 8'h80; // Bit 7 set marks a read
    localparam logic [6:0] ADDR_GPIO_CFG = 7'h01; // Pin direction/level
    localparam logic [6:0] ADDR_CLK_CFG = 7'h02; // Clock select field
    localparam logic [6:0] ADDR_IRQ_EN = 7'h03; // Interrupt enable
    localparam logic [6:0] ADDR_STATUS = 7'h04; // Status, read only
    localparam logic [6:0] ADDR_SCRATCH = 7'h05; // Free scratch word
    localparam logic [7:0] GPIO_CFG_RST = 8'h00; // Both pins inputs
    localparam logic [7:0] CLK_CFG_RST = 8'h00; // Internal clock
    localparam logic [7:0] IRQ_EN_RST = 8'h00; // Interrupt masked
    localparam logic [7:0] SCRATCH_RST = 8'h00; // Scratch cleared
    localparam logic EXT_CLOCK_ON = 1'b1; // Field value for pin 0
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CORE_CLK_HZ = 10000000; // Host core clock
    localparam int SCLK_DIV = 4; // Core cycles per half bit
endpackage

// >>> hw/spp_if.sv
`timescale 1ns/1ps
// Serial link between host and converter port
interface spp_if;
    logic sclk; // Serial clock from host
    logic device_select_n; // Active-low frame select
    logic serial_in; // Host to device data
    logic serial_out_irq_n; // Device data or interrupt, low active
    modport dev (
        input sclk,
        input device_select_n,
        input serial_in,
        output serial_out_irq_n
    );
    modport host (
        output sclk,
        output device_select_n,
        output serial_in,
        input serial_out_irq_n
    );
endinterface

// >>> hw/spp_host.sv
`timescale 1ns/1ps
module spp_host (
    spp_if.host LINK,
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic START,
    input wire logic [7:0] CMD,
    input wire logic [7:0] WDATA,
    output logic BUSY,
    output logic DONE,
    output logic [7:0] RDATA,
    output logic IRQ_N
);
    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    typedef enum {SPP_IDLE, SPP_SHIFT, SPP_GAP} spp_state_e;
    spp_state_e state_reg; // Frame sequencer
    logic [15:0] sh_reg; // Outgoing frame, MSB first
    logic [7:0] rx_reg; // Incoming bits
    logic [4:0] bit_reg; // Bits done
    logic [2:0] div_reg; // Half-bit divider
    logic sclk_reg; // Serial clock, idles low
    logic sel_n_reg; // Select, held low when idle
    logic [1:0] so_sync_reg; // Serial output synchroniser
    logic half; // Half-bit boundary
    assign half = (div_reg == 3'(spp_pkg::SCLK_DIV - 1));
    assign LINK.sclk = sclk_reg;
    assign LINK.device_select_n = sel_n_reg;
    assign LINK.serial_in = sh_reg[15];
    assign BUSY = (state_reg != SPP_IDLE);
    // Interrupt seen only while select is held low between frames
    assign IRQ_N = so_sync_reg[1] | (state_reg != SPP_IDLE);
    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK)
    begin
        so_sync_reg <= {so_sync_reg[0], LINK.serial_out_irq_n};
    end
    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    // Select stays low when idle so the interrupt level is watched;
    // a high pulse in the gap resets and frames the device port
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= SPP_IDLE;
            sclk_reg <= 1'b0;
            sel_n_reg <= 1'b1;
            div_reg <= 3'h0;
            bit_reg <= 5'h00;
            sh_reg <= 16'h0000;
            rx_reg <= 8'h00;
            RDATA <= 8'h00;
            DONE <= 1'b0;
        end
        else
        begin
            DONE <= 1'b0;
            div_reg <= half ? 3'h0 : div_reg + 3'h1;
            unique case (state_reg)
                SPP_IDLE:
                begin
                    sel_n_reg <= 1'b0;
                    if (START)
                    begin
                        sh_reg <= {CMD, WDATA};
                        bit_reg <= 5'h00;
                        div_reg <= 3'h0;
                        state_reg <= SPP_SHIFT;
                    end
                end
                SPP_SHIFT:
                    if (half)
                    begin
                        sclk_reg <= ~sclk_reg;
                        if (!sclk_reg)
                            // Rising: device samples; host reads too
                            rx_reg <= {rx_reg[6:0], so_sync_reg[1]};
                        else
                        begin
                            // Falling: next bit launched
                            sh_reg <= {sh_reg[14:0], 1'b0};
                            bit_reg <= bit_reg + 5'h01;
                            if (bit_reg == 5'(spp_pkg::FRAME_BITS - 1))
                            begin
                                sel_n_reg <= 1'b1;
                                state_reg <= SPP_GAP;
                            end
                        end
                    end
                SPP_GAP:
                    if (half)
                    begin
                        RDATA <= rx_reg;
                        DONE <= 1'b1;
                        state_reg <= SPP_IDLE;
                    end
            endcase
        end
    end
endmodule // spp_host

// >>> verification/spp_link_props.sv
`timescale 1ns/1ps
// Link watcher; the serial clock is a divided core clock, so one domain
module spp_link_props (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic sclk,
    input wire logic device_select_n,
    input wire logic serial_in,
    input wire logic serial_out_irq_n
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    logic [4:0] rise_reg; // Serial clock rises in the current frame
    // ------------------------------------------------------------
    // Frame bit counter, cleared while deselected
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST || device_select_n)
            rise_reg <= 5'h00;
        else if ($rose(sclk))
            rise_reg <= rise_reg + 5'h01;
    end
    property p_idle_clk;
        device_select_n |-> !sclk;
    endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("serial clock active while deselected");
    property p_sel_gap;
        $rose(device_select_n) |-> device_select_n[*4];
    endproperty
    a_sel_gap: assert property (p_sel_gap)
        else $error("select high gap shorter than four cycles");
    property p_frame_len;
        $rose(device_select_n) |-> rise_reg == 5'h10;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame did not carry sixteen bits");
    property p_sin_hold;
        sclk && $past(sclk) |-> $stable(serial_in);
    endproperty
    a_sin_hold: assert property (p_sin_hold)
        else $error("serial input moved while clock high");
    property p_sout_hold;
        sclk && $past(sclk) && !device_select_n |-> $stable(serial_out_irq_n);
    endproperty
    a_sout_hold: assert property (p_sout_hold)
        else $error("serial output moved while clock high");
    property p_half_hi;
        $rose(sclk) |-> sclk[*4] ##1 !sclk;
    endproperty
    a_half_hi: assert property (p_half_hi)
        else $error("clock high phase not four cycles");
    property p_half_lo;
        $fell(sclk) && !device_select_n |-> !sclk[*4];
    endproperty
    a_half_lo: assert property (p_half_lo)
        else $error("clock low phase too short");
    property p_rise_sel;
        $rose(sclk) |-> !device_select_n throughout ##3 1'b1;
    endproperty
    a_rise_sel: assert property (p_rise_sel)
        else $error("select released during a clock high phase");
endmodule // spp_link_props

// >>> verification/serial_port_pin_behaviour_tb.sv
`timescale 1ns/1ps
module serial_port_pin_behaviour_tb;
    logic core_clk = 1'b0; // 100 ns core clock
    logic int_clk = 1'b0; // Internal conversion clock
    logic sys_rst = 1'b1; // Host reset
    logic dev_rst = 1'b1; // Device reset, needs frames to land
    logic irq_event = 1'b0;
    logic gio0_i = 1'b0;
    logic gio1_i = 1'b0;
    logic start = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic busy, done, irq_n, gio0_o, gio0_oe, gio1_o, gio1_oe;
    logic conv_clk, ext_clk_sel;
    logic [7:0] rdata;
    int err_count = 0;
    int checks = 0;
    spp_if link_if ();
    spp_host spp_host_i (.LINK(link_if), .CORE_CLK(core_clk),
        .SYS_RST(sys_rst), .START(start), .CMD(cmd), .WDATA(wdata),
        .BUSY(busy), .DONE(done), .RDATA(rdata), .IRQ_N(irq_n));
    spp_device spp_device_i (.LINK(link_if), .SYS_RST(dev_rst),
        .INT_CLK(int_clk), .IRQ_EVENT(irq_event), .GIO0_I(gio0_i),
        .GIO0_O(gio0_o), .GIO0_OE(gio0_oe), .GIO1_I(gio1_i),
        .GIO1_O(gio1_o), .GIO1_OE(gio1_oe), .CONV_CLK(conv_clk),
        .EXT_CLK_SEL(ext_clk_sel));
    spp_link_props spp_link_props_i (.CORE_CLK(core_clk),
        .SYS_RST(dev_rst), .sclk(link_if.sclk),
        .device_select_n(link_if.device_select_n),
        .serial_in(link_if.serial_in),
        .serial_out_irq_n(link_if.serial_out_irq_n));
    always #50 core_clk = ~core_clk;
    always #16 int_clk = ~int_clk;
    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s,
        input logic [7:0] e);
        checks++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One frame; waits on DONE under a bound, then one idle cycle
    task automatic xfer(input logic [7:0] c, input logic [7:0] w);
        int n;
        @(negedge core_clk);
        start = 1'b1;
        cmd = c;
        wdata = w;
        @(negedge core_clk);
        start = 1'b0;
        chk("busy", 8'(busy), 8'h01);
        n = 0;
        while (done !== 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("done", 8'(done), 8'h01);
        chk("busy_end", 8'(busy), 8'h00);
        if (n >= 400)
            give_verdict();
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        xfer({1'b0, a}, d);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        xfer(spp_pkg::CMD_READ_BIT | {1'b0, a}, 8'h00);
        chk("rdata", rdata, e);
    endtask
    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (irq_n !== e && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("irq_n", 8'(irq_n), 8'(e));
        if (n >= 20)
            give_verdict();
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(spp_pkg::ADDR_GPIO_CFG, spp_pkg::GPIO_CFG_RST);
        rd(spp_pkg::ADDR_CLK_CFG, spp_pkg::CLK_CFG_RST);
        rd(spp_pkg::ADDR_IRQ_EN, spp_pkg::IRQ_EN_RST);
        wr(spp_pkg::ADDR_SCRATCH, 8'hA5);
        rd(spp_pkg::ADDR_SCRATCH, 8'hA5);
        wr(spp_pkg::ADDR_SCRATCH, 8'h3C);
        rd(spp_pkg::ADDR_SCRATCH, 8'h3C);
        wr(7'h7F, 8'hFF);
        rd(7'h7F, 8'h00);
        $display("test registers done");
    endtask
    task automatic t_gpio();
        wr(spp_pkg::ADDR_GPIO_CFG, 8'h07);
        chk("gio_oe", {6'h00, gio1_oe, gio0_oe}, 8'h03);
        chk("gio_o", {6'h00, gio1_o, gio0_o}, 8'h01);
        wr(spp_pkg::ADDR_GPIO_CFG, 8'h00);
        gio0_i = 1'b1;
        rd(spp_pkg::ADDR_STATUS, 8'h02);
        gio0_i = 1'b0;
        gio1_i = 1'b1;
        rd(spp_pkg::ADDR_STATUS, 8'h04);
        gio1_i = 1'b0;
        $display("test gpio done");
    endtask
    task automatic t_ext_clock_select();
        wr(spp_pkg::ADDR_GPIO_CFG, 8'h01);
        wr(spp_pkg::ADDR_CLK_CFG, 8'h01);
        chk("ext_sel", 8'(ext_clk_sel), 8'h01);
        chk("gio0_oe", 8'(gio0_oe), 8'h00);
        gio0_i = 1'b1;
        @(negedge core_clk);
        chk("conv_clk", 8'(conv_clk), 8'h01);
        gio0_i = 1'b0;
        @(negedge core_clk);
        chk("conv_clk", 8'(conv_clk), 8'h00);
        wr(spp_pkg::ADDR_CLK_CFG, 8'h00);
        chk("ext_sel", 8'(ext_clk_sel), 8'h00);
        chk("conv_int", 8'(conv_clk), 8'(int_clk));
        chk("gio0_oe", 8'(gio0_oe), 8'h01);
        wr(spp_pkg::ADDR_GPIO_CFG, 8'h00);
        $display("test external clock done");
    endtask
    task automatic t_irq();
        irq_event = 1'b1;
        repeat (12) @(negedge core_clk);
        wait_irq(1'b1);
        wr(spp_pkg::ADDR_IRQ_EN, 8'h01);
        wait_irq(1'b0);
        rd(spp_pkg::ADDR_STATUS, 8'h01);
        wait_irq(1'b0);
        irq_event = 1'b0;
        wait_irq(1'b1);
        wr(spp_pkg::ADDR_IRQ_EN, 8'h00);
        $display("test interrupt done");
    endtask
    // Device reset only lands on serial clock edges, so frames flush it
    initial
    begin
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
        wr(spp_pkg::ADDR_SCRATCH, 8'h00);
        dev_rst = 1'b0;
        wr(spp_pkg::ADDR_SCRATCH, 8'h00);
        t_regs();
        t_gpio();
        t_ext_clock_select();
        t_irq();
        give_verdict();
    end
endmodule // serial_port_pin_behaviour_tb
